// [ppl_map.vh]
// register offsets, field positions and reset values of the printer port pin logic
`ifndef PPL_MAP_VH
`define PPL_MAP_VH

// register offsets (word index on the plain register port)
`define PPL_ADDR_W 4
`define PPL_OFS_DATA 4'h0
`define PPL_OFS_STATUS 4'h1
`define PPL_OFS_CONTROL 4'h2

// control register fields
`define PPL_CTL_STROBE 0
`define PPL_CTL_AUTOFEED 1
`define PPL_CTL_INIT 2
`define PPL_CTL_SELECT 3
`define PPL_CTL_DIR 5

// status register fields
`define PPL_STS_FAULT 3
`define PPL_STS_ONLINE 4
`define PPL_STS_PAPER 5
`define PPL_STS_ACK 6
`define PPL_STS_BUSY 7

// reset values
`define PPL_DATA_RST 8'h00
`define PPL_CTL_RST 8'h04

`endif

// [ppl_port.v]
// printer parallel port pin logic: control/status/data registers mapped onto printer pins
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ppl_map.vh"

module ppl_port #(
  parameter DATA_W = 8
) (
  // clock and reset
  input wire CLK_SYS_I,
  input wire RST_I,
  // register port
  input wire [`PPL_ADDR_W-1:0] REG_ADDR_I,
  input wire [7:0] REG_WDATA_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  output reg [7:0] REG_RDATA_O,
  // printer status inputs
  input wire ACK_N_I,
  input wire BUSY_I,
  input wire FAULT_N_I,
  input wire PRINTER_ONLINE_I,
  input wire PAPER_OUT_I,
  // printer control outputs (open drain; strobe, autofeed and select pins low while enable high, init pin low while enable low)
  output wire STROBE_N_O,
  output wire AUTO_LINE_FEED_N_O,
  output wire INIT_N_O,
  output wire PRINTER_SELECT_OUT_N_O,
  // port data lines, bit 7 down to bit 0
  input wire [DATA_W-1:0] PORT_DATA_I,
  output wire [DATA_W-1:0] PORT_DATA_O,
  output wire [DATA_W-1:0] PORT_DATA_OE_O
);

  // limitations: inputs come straight from the cable with no filter or
  // synchroniser, so they must already be clean and in this clock domain;
  // strobe pulse width and data setup are left entirely to software
  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // one decoder serves both the write side and the read side
  function is_index;
    input [`PPL_ADDR_W-1:0] addr;
    input [`PPL_ADDR_W-1:0] index;
    begin
      is_index = (addr == index);
    end
  endfunction

  // bits 7:6 of the control register hold nothing and read back as zero
  function [7:0] ctl_clean;
    input [7:0] value;
    begin
      ctl_clean = {2'h0, value[5:0]};
    end
  endfunction

  // the strobe, autofeed and select pins show the inverse of their control bits; INIT_N_O does not
  function drive_low;
    input ctl_bit;
    begin
      drive_low = ~ctl_bit;
    end
  endfunction

  // fixed priority; the selects are exclusive anyway since one index decodes
  function [7:0] read_pick;
    input pick_data;
    input pick_status;
    input pick_ctl;
    input [7:0] data_byte;
    input [7:0] status_byte;
    input [7:0] ctl_byte;
    begin
      if (pick_data) begin
        read_pick = data_byte;
      end else if (pick_status) begin
        read_pick = status_byte;
      end else if (pick_ctl) begin
        read_pick = ctl_byte;
      end else begin
        read_pick = 8'h00;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // stored state
  reg [DATA_W-1:0] data_reg;

  reg [DATA_W-1:0] data_next;

  reg [7:0] ctl_reg;

  reg [7:0] ctl_next;

  // read side
  reg [7:0] rdata_next;

  reg [7:0] rdata_out_next;

  reg [7:0] status_bits;

  reg [DATA_W-1:0] data_read;

  // access decode
  wire wr_data;

  wire wr_ctl;

  wire sel_data;

  wire sel_status;

  wire sel_ctl;

  // control register fields
  wire ctl_strobe;

  wire ctl_autofeed;

  wire ctl_init;

  wire ctl_select;

  wire ctl_dir;

  // printer status levels
  wire ack_level;

  wire busy_level;

  wire fault_level;

  wire online_level;

  wire paper_level;

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  // every index outside the three mapped ones is unmapped
  assign sel_data = is_index(REG_ADDR_I, `PPL_OFS_DATA);

  assign sel_status = is_index(REG_ADDR_I, `PPL_OFS_STATUS);

  assign sel_ctl = is_index(REG_ADDR_I, `PPL_OFS_CONTROL);

  // writes to the status index or to unmapped indices fall through silently
  assign wr_data = REG_WR_I & sel_data;

  assign wr_ctl = REG_WR_I & sel_ctl;

  ////////////////////////////////////////////////////////////////////////////
  // data register

  always @* begin
    if (wr_data) begin
      data_next = REG_WDATA_I[DATA_W-1:0];
    end else begin
      data_next = data_reg;
    end
  end

  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      data_reg <= `PPL_DATA_RST;
    end else begin
      data_reg <= data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always @* begin
    if (wr_ctl) begin
      ctl_next = ctl_clean(REG_WDATA_I);
    end else begin
      ctl_next = ctl_reg;
    end
  end

  // reset leaves initialise high so the printer is not held in reset
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ctl_reg <= `PPL_CTL_RST;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign ctl_strobe = ctl_reg[`PPL_CTL_STROBE];

  assign ctl_autofeed = ctl_reg[`PPL_CTL_AUTOFEED];

  assign ctl_init = ctl_reg[`PPL_CTL_INIT];

  assign ctl_select = ctl_reg[`PPL_CTL_SELECT];

  // a direction change acts at the same edge as the write; no turnaround
  // gap is inserted, so the far side must release the lines first
  assign ctl_dir = ctl_reg[`PPL_CTL_DIR];

  ////////////////////////////////////////////////////////////////////////////
  // control pins; inputs treated as synchronous, so no synchroniser here

  // the strobe pulse width is whatever software makes it; nothing times it here
  assign STROBE_N_O = drive_low(ctl_strobe);

  assign AUTO_LINE_FEED_N_O = drive_low(ctl_autofeed);

  assign INIT_N_O = ctl_init;

  assign PRINTER_SELECT_OUT_N_O = drive_low(ctl_select);

  ////////////////////////////////////////////////////////////////////////////
  // data path: direction bit high turns the port round to read

  assign PORT_DATA_O = data_reg;

  // the enable fans out to every line; there is no per-bit direction
  assign PORT_DATA_OE_O = {DATA_W{~ctl_dir}};

  // reading while driving returns the written value, not the cable
  always @* begin
    if (ctl_dir) begin
      data_read = PORT_DATA_I;
    end else begin
      data_read = data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: live pin levels, nothing latched

  assign ack_level = ACK_N_I;

  assign busy_level = BUSY_I;

  assign fault_level = FAULT_N_I;

  assign online_level = PRINTER_ONLINE_I;

  assign paper_level = PAPER_OUT_I;

  // unused low bits read zero
  always @* begin
    status_bits = 8'h00;
    status_bits[`PPL_STS_FAULT] = fault_level;

    status_bits[`PPL_STS_ONLINE] = online_level;

    status_bits[`PPL_STS_PAPER] = paper_level;

    status_bits[`PPL_STS_ACK] = ack_level;

    status_bits[`PPL_STS_BUSY] = busy_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and read data register

  // unmapped indices read as zero
  always @* begin
    rdata_next = read_pick(sel_data, sel_status, sel_ctl,
                           data_read, status_bits, ctl_reg);
  end

  // zero outside a read so stale data never lingers on the bus
  always @* begin
    rdata_out_next = 8'h00;
    if (REG_RD_I) begin
      rdata_out_next = rdata_next;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else begin
      REG_RDATA_O <= rdata_out_next;
    end
  end

endmodule
`default_nettype wire

// [ppl_printer.sv]
// printer model on the cable side
`timescale 1ns/1ns
`default_nettype none
module ppl_printer (
  input wire logic CLK_SYS_I, STROBE_N_O,
  input wire logic [7:0] PORT_DATA_O, PORT_DATA_OE_O,
  output logic ACK_N_I = 1'b1,
  output logic [7:0] PORT_DATA_I);
  // printer fills only released lines, so a read never sees stale host data
  assign PORT_DATA_I = PORT_DATA_O & PORT_DATA_OE_O | 8'h3c & ~PORT_DATA_OE_O;
  always @(posedge CLK_SYS_I) ACK_N_I <= STROBE_N_O;
endmodule
`default_nettype wire

// [ppl_sva.sv]
// status bit, port data, idle read data and control pin assertions for the printer port
`timescale 1ns/1ns
`default_nettype none
module ppl_sva (
  input wire logic CLK_SYS_I, RST_I, REG_WR_I, STROBE_N_O, INIT_N_O,
  input wire logic AUTO_LINE_FEED_N_O, PRINTER_SELECT_OUT_N_O,
  input wire logic REG_RD_I, ACK_N_I, FAULT_N_I, PRINTER_ONLINE_I, PAPER_OUT_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I, REG_RDATA_O, PORT_DATA_O);
  chk_ack_status: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I == 4'h1 |=> REG_RDATA_O[6] == $past(ACK_N_I))
    else $error("acknowledge status bit wrong");
  chk_fault_status: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I == 4'h1 |=> REG_RDATA_O[3] == $past(FAULT_N_I))
    else $error("fault status bit wrong");
  chk_online_status: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I == 4'h1 |=> REG_RDATA_O[4] == $past(PRINTER_ONLINE_I))
    else $error("online status bit wrong");
  chk_paper_status: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I == 4'h1 |=> REG_RDATA_O[5] == $past(PAPER_OUT_I))
    else $error("paper status bit wrong");
  chk_data_latch: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == 4'h0 |=> PORT_DATA_O == $past(REG_WDATA_I))
    else $error("port data not written");
  chk_rdata_idle: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !REG_RD_I |=> REG_RDATA_O == 8'h00)
    else $error("read data outside read cycle");
  chk_ctl_pins: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == 4'h2 |=> ($past(REG_WDATA_I[3:0]) ^ 4'hb) ==
    {PRINTER_SELECT_OUT_N_O, INIT_N_O, AUTO_LINE_FEED_N_O, STROBE_N_O})
    else $error("control pins wrong");
endmodule
bind ppl_port ppl_sva ppl_sva_i (.*);
`default_nettype wire

// [testbench.sv]
// self-checking bench for the printer port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic CLK_SYS_I = 0, RST_I = 1, REG_WR_I = 0, REG_RD_I = 0, BUSY_I = 0, FAULT_N_I = 0;
  logic PRINTER_ONLINE_I = 0, PAPER_OUT_I = 0, ACK_N_I, STROBE_N_O, AUTO_LINE_FEED_N_O;
  logic INIT_N_O, PRINTER_SELECT_OUT_N_O;
  logic [3:0] REG_ADDR_I = 0;
  logic [7:0] REG_WDATA_I = 0, REG_RDATA_O, PORT_DATA_I, PORT_DATA_O, PORT_DATA_OE_O;
  int n_fail = 0, tests_run = 0;
  always #5 CLK_SYS_I = ~CLK_SYS_I;
  ppl_port ppl_port_i (.*);
  ppl_printer ppl_printer_i (.*);
  task chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    {REG_WR_I, REG_RD_I, REG_ADDR_I, REG_WDATA_I} <= {w, !w, a, d};
    @(posedge CLK_SYS_I);
    {REG_WR_I, REG_RD_I} <= 2'b00;
    #1;
  endtask
  task conclude;
    $display("%0d checks, %0d failed", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // the sequence needs about 1000 ns
  initial begin
    #5000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge CLK_SYS_I);
    RST_I <= 0;
    chk({4'h0, PRINTER_SELECT_OUT_N_O, INIT_N_O, AUTO_LINE_FEED_N_O, STROBE_N_O}, 8'h0f);
    for (int i = 0; i < 32; i++) begin
      acc(1, 2, i[7:0]);
      acc(1, 0, i[7:0]);
      chk(PORT_DATA_O, i[7:0]);
      chk({4'h0, PRINTER_SELECT_OUT_N_O, INIT_N_O, AUTO_LINE_FEED_N_O, STROBE_N_O}, {4'h0, i[3:0] ^ 4'hb});
      chk(PORT_DATA_OE_O, 8'hff);
      {BUSY_I, PAPER_OUT_I, PRINTER_ONLINE_I, FAULT_N_I} <= i[4:1];
      acc(0, 1, 0);
      chk(REG_RDATA_O, {i[4], ~i[0], i[3:1], 3'h0});
    end
    acc(1, 2, 8'he0);
    acc(0, 2, 0);
    chk(REG_RDATA_O, 8'h20);
    acc(0, 0, 0);
    chk(REG_RDATA_O, 8'h3c);
    chk(PORT_DATA_OE_O, 8'h00);
    acc(0, 4'hf, 0);
    chk(REG_RDATA_O, 0);
    conclude();
  end
endmodule
`default_nettype wire
